// ===== include/vic_pkg.sv
// Package of constants and types for the vectored interrupt control block.
package vic_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [15:0] ADDR_EDGE_RISE = 16'hFF48;
  localparam logic [15:0] ADDR_EDGE_FALL = 16'hFF49;
  localparam logic [15:0] ADDR_REQ_LO = 16'hFFE0;
  localparam logic [15:0] ADDR_REQ_HI = 16'hFFE1;
  localparam logic [15:0] ADDR_MASK_LO = 16'hFFE4;
  localparam logic [15:0] ADDR_MASK_HI = 16'hFFE5;
  localparam logic [15:0] ADDR_PRIO_LO = 16'hFFE8;
  localparam logic [15:0] ADDR_PRIO_HI = 16'hFFE9;
  localparam logic [15:0] ADDR_PSW = 16'hFF1E;

  // ---------------------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_REQ = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_PRIO = 8'hFF;
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [7:0] RST_PSW = 8'h02;
  localparam int PSW_IE_BIT = 7;
  localparam int PSW_ISP_BIT = 1;
  localparam int NUM_MASKABLE = 12;
  localparam int SRC_W = 4;
  localparam logic [15:0] RST_MASK16 = 16'hFFFF;

  // ---------------------------------------------------------------------------
  // Vectors
  // ---------------------------------------------------------------------------
  localparam logic [15:0] VEC_NMI = 16'h0004;
  localparam logic [15:0] VEC_WDT_MASKABLE = 16'h0004;
  localparam logic [15:0] VEC_PIN0 = 16'h0006;
  localparam logic [15:0] VEC_PIN1 = 16'h0008;
  localparam logic [15:0] VEC_INT_BASE = 16'h000A;
  localparam logic [15:0] VEC_BREAK = 16'h003E;
  localparam int FIRST_INTERNAL = 3;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    VIC_KIND_MASKABLE = 2'b00,
    VIC_KIND_NMI = 2'b01,
    VIC_KIND_BREAK = 2'b10
  } vic_kind_t;

  typedef enum logic [1:0] {
    VIC_RUN_IDLE = 2'b00,
    VIC_RUN_NMI = 2'b01
  } vic_run_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic wide;
    logic [15:0] addr;
    logic [15:0] wdata;
  } vic_bus_t;

  typedef struct packed {
    logic valid;
    vic_kind_t kind;
    logic [SRC_W-1:0] src;
    logic [15:0] vector;
  } vic_req_t;

  typedef struct packed {
    logic ei;
    logic di;
    logic break_trap_instruction;
    logic interrupt_return_instruction;
    logic break_return_instruction;
    logic pop_psw;
    logic [7:0] pop_data;
    logic ack;
  } vic_cpu_t;

endpackage

// ===== src/vic_top.sv
// Vectored interrupt control: request, mask, priority flags, arbitration and status word.
`timescale 1ns/100ps
`default_nettype none

module vic_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire vic_pkg::vic_bus_t bus,
  output logic [15:0] rdata,
  input wire vic_pkg::vic_cpu_t cpu,
  input wire logic wdt_nmi_mode,
  input wire logic wdt_overflow,
  input wire logic [1:0] ext_pin,
  input wire logic [8:0] periph_irq,
  output vic_pkg::vic_req_t irq_req,
  output logic [7:0] psw_push,
  output logic standby_release
);
  import vic_pkg::*;

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  // The release is synchronised so that every flop past the two-stage synchroniser leaves reset on the same edge.
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire logic arst_n = rst_s2_reg;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [15:0] req_reg;
  logic [15:0] req_next;
  logic [15:0] mask_reg;
  logic [15:0] mask_next;
  logic [15:0] prio_reg;
  logic [15:0] prio_next;
  logic [7:0] rise_reg;
  logic [7:0] fall_reg;
  logic [7:0] psw_reg;
  logic [7:0] psw_next;
  logic [1:0] pin_prev_reg;
  logic nmi_pend_reg;
  logic nmi_pend_next;
  vic_run_t run_reg;
  vic_run_t run_next;
  vic_req_t req_out_reg;
  vic_req_t req_out_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [7:0] push_reg;
  logic [7:0] push_next;
  logic stby_reg;

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  // A wide access at the low address writes both bytes of a pair at once.
  wire logic wr_req_lo = bus.wr_en && bus.addr == ADDR_REQ_LO;
  wire logic wr_req_hi = bus.wr_en && (bus.addr == ADDR_REQ_HI || (bus.wide && bus.addr == ADDR_REQ_LO));
  wire logic wr_mask_lo = bus.wr_en && bus.addr == ADDR_MASK_LO;
  wire logic wr_mask_hi = bus.wr_en && (bus.addr == ADDR_MASK_HI || (bus.wide && bus.addr == ADDR_MASK_LO));
  wire logic wr_prio_lo = bus.wr_en && bus.addr == ADDR_PRIO_LO;
  wire logic wr_prio_hi = bus.wr_en && (bus.addr == ADDR_PRIO_HI || (bus.wide && bus.addr == ADDR_PRIO_LO));
  wire logic wr_rise = bus.wr_en && bus.addr == ADDR_EDGE_RISE;
  wire logic wr_fall = bus.wr_en && bus.addr == ADDR_EDGE_FALL;
  wire logic wr_psw = bus.wr_en && bus.addr == ADDR_PSW;
  wire logic [7:0] hi_byte = bus.wide ? bus.wdata[15:8] : bus.wdata[7:0];
  wire logic [7:0] rise_next = wr_rise ? {6'h00, bus.wdata[1:0]} : rise_reg;
  wire logic [7:0] fall_next = wr_fall ? {6'h00, bus.wdata[1:0]} : fall_reg;

  // ---------------------------------------------------------------------------
  // Source events
  // ---------------------------------------------------------------------------
  // The watchdog reaches the maskable flag only in interval mode.
  wire logic [1:0] pin_rise = ext_pin & ~pin_prev_reg;
  wire logic [1:0] pin_fall = ~ext_pin & pin_prev_reg;
  wire logic [1:0] pin_evt = (pin_rise & rise_reg[1:0]) | (pin_fall & fall_reg[1:0]);
  wire logic [NUM_MASKABLE-1:0] src_evt = {periph_irq, pin_evt, wdt_overflow & ~wdt_nmi_mode};

  // ---------------------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------------------
  // The lowest set bit of the chosen group wins, which gives rank 0 the lead.
  wire logic [NUM_MASKABLE-1:0] live = req_reg[NUM_MASKABLE-1:0] & ~mask_reg[NUM_MASKABLE-1:0];
  wire logic [NUM_MASKABLE-1:0] live_hi = live & ~prio_reg[NUM_MASKABLE-1:0];
  wire logic [NUM_MASKABLE-1:0] group = (|live_hi) ? live_hi : live;
  wire logic [NUM_MASKABLE-1:0] onehot = group & (~group + 12'h001);
  wire logic in_service_priority = psw_reg[PSW_ISP_BIT];
  wire logic ie = psw_reg[PSW_IE_BIT];
  wire logic win_hi = |live_hi;
  wire logic can_take = (|live) && ie && (run_reg == VIC_RUN_IDLE) && (win_hi || in_service_priority);
  // Standby release ignores the enable bit: a masked-in request wakes the core even when disabled.
  wire logic stby_next = (|live) || nmi_pend_reg;

  logic [SRC_W-1:0] win_idx;
  logic [15:0] win_vec;
  always_comb begin
    win_idx = '0;
    for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
      if (onehot[i]) begin
        win_idx = SRC_W'(i);
      end
    end
  end

  // Vectors: watchdog and pins fixed, internal sources two apart.
  always_comb begin
    case (win_idx)
      4'h0: win_vec = VEC_WDT_MASKABLE;
      4'h1: win_vec = VEC_PIN0;
      4'h2: win_vec = VEC_PIN1;
      default: win_vec = VEC_INT_BASE + {11'h000, win_idx - 4'h3, 1'b0};
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  wire logic nmi_take = nmi_pend_reg && (run_reg == VIC_RUN_IDLE);
  wire logic take_ack = cpu.ack && req_out_reg.valid;
  wire logic ack_mask = take_ack && req_out_reg.kind == VIC_KIND_MASKABLE;
  // Only a maskable acknowledge clears a flag; the non-maskable path keeps no flag bit.
  wire logic [15:0] ack_clr = ack_mask ? (16'h0001 << req_out_reg.src) : 16'h0000;

  always_comb begin
    // Set wins over an instruction clear in the same cycle.
    req_next = req_reg;
    if (wr_req_lo) req_next[7:0] = bus.wdata[7:0];
    if (wr_req_hi) req_next[15:8] = hi_byte;
    req_next = (req_next & ~ack_clr) | {4'h0, src_evt};
    mask_next = mask_reg;
    if (wr_mask_lo) mask_next[7:0] = bus.wdata[7:0];
    if (wr_mask_hi) mask_next[15:8] = hi_byte;
    prio_next = prio_reg;
    if (wr_prio_lo) prio_next[7:0] = bus.wdata[7:0];
    if (wr_prio_hi) prio_next[15:8] = hi_byte;
  end

  // Later lines win: an acknowledge overrides an instruction touching the same bit.
  always_comb begin
    psw_next = psw_reg;
    push_next = push_reg;
    run_next = run_reg;
    nmi_pend_next = nmi_pend_reg;
    req_out_next = req_out_reg;
    if (wr_psw) psw_next = bus.wdata[7:0];
    if (cpu.ei) psw_next[PSW_IE_BIT] = 1'b1;
    if (cpu.di) psw_next[PSW_IE_BIT] = 1'b0;
    if (cpu.pop_psw || cpu.break_return_instruction) psw_next = cpu.pop_data;
    if (cpu.interrupt_return_instruction) begin
      psw_next = cpu.pop_data;
      run_next = VIC_RUN_IDLE;
    end
    if (cpu.break_trap_instruction) begin
      push_next = psw_reg;
      psw_next[PSW_IE_BIT] = 1'b0;
    end
    if (take_ack) begin
      push_next = psw_reg;
      psw_next[PSW_IE_BIT] = 1'b0;
      req_out_next.valid = 1'b0;
      case (req_out_reg.kind)
        VIC_KIND_NMI: begin
          psw_next[PSW_ISP_BIT] = 1'b0;
          run_next = VIC_RUN_NMI;
        end
        VIC_KIND_MASKABLE: psw_next[PSW_ISP_BIT] = prio_reg[req_out_reg.src];
        default: psw_next[PSW_ISP_BIT] = psw_reg[PSW_ISP_BIT];
      endcase
    end else if (!req_out_reg.valid && !cpu.break_trap_instruction) begin
      if (nmi_take) begin
        req_out_next = '{valid: 1'b1, kind: VIC_KIND_NMI, src: 4'hF, vector: VEC_NMI};
        nmi_pend_next = 1'b0;
      end else if (can_take) begin
        req_out_next = '{valid: 1'b1, kind: VIC_KIND_MASKABLE, src: win_idx, vector: win_vec};
      end
    end else if (cpu.break_trap_instruction && !req_out_reg.valid) begin
      req_out_next = '{valid: 1'b0, kind: VIC_KIND_BREAK, src: 4'h0, vector: VEC_BREAK};
    end
    // Several overflows during service collapse to one pending request.
    if (wdt_overflow && wdt_nmi_mode) nmi_pend_next = 1'b1;
  end

  // Readback: the combined word sits at the low address; undefined watchdog mask read is tolerated.
  always_comb begin
    case (bus.addr)
      ADDR_REQ_LO: rdata_next = bus.wide ? req_reg : {8'h00, req_reg[7:0]};
      ADDR_REQ_HI: rdata_next = {8'h00, req_reg[15:8]};
      ADDR_MASK_LO: rdata_next = bus.wide ? mask_reg : {8'h00, mask_reg[7:0]};
      ADDR_MASK_HI: rdata_next = {8'h00, mask_reg[15:8]};
      ADDR_PRIO_LO: rdata_next = bus.wide ? prio_reg : {8'h00, prio_reg[7:0]};
      ADDR_PRIO_HI: rdata_next = {8'h00, prio_reg[15:8]};
      ADDR_EDGE_RISE: rdata_next = {8'h00, rise_reg};
      ADDR_EDGE_FALL: rdata_next = {8'h00, fall_reg};
      ADDR_PSW: rdata_next = {8'h00, psw_reg};
      default: rdata_next = 16'h0000;
    endcase
    if (!bus.rd_en) rdata_next = rdata_reg;
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // Flag registers.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_reg <= {RST_REQ, RST_REQ};
      mask_reg <= RST_MASK16;
      prio_reg <= {RST_PRIO, RST_PRIO};
    end else begin
      req_reg <= req_next;
      mask_reg <= mask_next;
      prio_reg <= prio_next;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rise_reg <= RST_EDGE;
      fall_reg <= RST_EDGE;
      pin_prev_reg <= 2'b00;
    end else begin
      rise_reg <= rise_next;
      fall_reg <= fall_next;
      pin_prev_reg <= ext_pin;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      psw_reg <= RST_PSW;
      run_reg <= VIC_RUN_IDLE;
      nmi_pend_reg <= 1'b0;
    end else begin
      psw_reg <= psw_next;
      run_reg <= run_next;
      nmi_pend_reg <= nmi_pend_next;
    end
  end

  // Outputs to the core all leave from flops.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_out_reg <= '0;
      push_reg <= 8'h00;
      stby_reg <= 1'b0;
    end else begin
      req_out_reg <= req_out_next;
      push_reg <= push_next;
      stby_reg <= stby_next;
    end
  end

  // Read data holds between reads, so a slow core may sample it late.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign irq_req = req_out_reg;
  assign rdata = rdata_reg;
  assign psw_push = push_reg;
  assign standby_release = stby_reg;

endmodule // vic_top

`default_nettype wire

// ===== bench/vic_assertions.sv
// Checker for the vectored interrupt control block ports.
`timescale 1ns/100ps
`default_nettype none
module vic_assertions (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire vic_pkg::vic_bus_t bus,
  input wire logic [15:0] rdata,
  input wire vic_pkg::vic_cpu_t cpu,
  input wire logic wdt_nmi_mode,
  input wire logic wdt_overflow,
  input wire logic [1:0] ext_pin,
  input wire logic [8:0] periph_irq,
  input wire vic_pkg::vic_req_t irq_req,
  input wire logic [7:0] psw_push,
  input wire logic standby_release
);
  import vic_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic mskb = irq_req.valid && irq_req.kind == VIC_KIND_MASKABLE;
  sequence nmi_ev;
    wdt_nmi_mode && wdt_overflow;
  endsequence
  valid_hold_a: assert property (irq_req.valid && !cpu.ack |=> irq_req.valid)
    else $error("request dropped before acknowledge");
  ack_drop_a: assert property (irq_req.valid && cpu.ack |=> !irq_req.valid)
    else $error("request stays after acknowledge");
  nmi_vec_a: assert property (irq_req.valid && irq_req.kind == VIC_KIND_NMI |->
    irq_req.vector == VEC_NMI && irq_req.src == 4'hF)
    else $error("wrong non-maskable vector");
  int_vec_a: assert property (mskb && irq_req.src >= 4'h3 |->
    irq_req.vector == VEC_INT_BASE + {11'h000, irq_req.src - 4'h3, 1'b0})
    else $error("wrong internal vector");
  pin_vec_a: assert property (mskb && irq_req.src inside {4'h1, 4'h2} |->
    irq_req.vector == {11'h000, irq_req.src, 1'b0} + 16'h0004)
    else $error("wrong pin vector");
  src_range_a: assert property (mskb |-> irq_req.src <= 4'hB)
    else $error("maskable source out of range");
  nmi_wake_a: assert property (nmi_ev |-> ##[1:4] standby_release)
    else $error("no standby release on non-maskable request");
  rdata_hold_a: assert property (!bus.rd_en |=> $stable(rdata))
    else $error("read data changed without a read");
endmodule // vic_assertions
`default_nettype wire

// ===== bench/vic_cpu_model.sv
// Core-side model that acknowledges vectored requests after a set wait.
`timescale 1ns/100ps
`default_nettype none
module vic_cpu_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire vic_pkg::vic_req_t irq_req,
  input wire logic [1:0] delay,
  output logic ack
);
  import vic_pkg::*;
  logic [1:0] cnt_reg;
  // ----------------------------------------
  // Acknowledge
  // ----------------------------------------
  // Ack is offered only while a request stands and never on two cycles running.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 2'h0;
      ack <= 1'b0;
    end else if (irq_req.valid && !ack && cnt_reg == delay) begin
      cnt_reg <= 2'h0;
      ack <= 1'b1;
    end else begin
      cnt_reg <= (irq_req.valid && !ack) ? cnt_reg + 2'h1 : 2'h0;
      ack <= 1'b0;
    end
  end
endmodule // vic_cpu_model
`default_nettype wire

// ===== bench/vic_top_test.sv
// Self-checking bench for the vectored interrupt control block.
`timescale 1ns/100ps
`default_nettype none
module vic_top_test;
  import vic_pkg::*;
  // ----------------------------------------
  // Stimulus and scoreboard
  // ----------------------------------------
  localparam vic_cpu_t EI = '{ei: 1'b1, default: '0};
  localparam vic_cpu_t INTERRUPT_RETURN_INSTRUCTION = '{interrupt_return_instruction: 1'b1, pop_data: 8'h82, default: '0};
  localparam logic [15:0] RA [9] = '{ADDR_EDGE_RISE, ADDR_EDGE_FALL, ADDR_REQ_LO, ADDR_REQ_HI,
    ADDR_MASK_LO, ADDR_MASK_HI, ADDR_PRIO_LO, ADDR_PRIO_HI, ADDR_PSW};
  localparam logic [7:0] RV [9] = '{RST_EDGE, RST_EDGE, RST_REQ, RST_REQ, RST_MASK, RST_MASK,
    RST_PRIO, RST_PRIO, RST_PSW};
  logic ref_clk, rst_n, wdt_nmi_mode, wdt_overflow, ack, standby_release, rd_q, v_q;
  logic [1:0] ext_pin, dly;
  logic [8:0] periph_irq;
  logic [15:0] rdata;
  logic [7:0] psw_push;
  vic_bus_t bus;
  vic_cpu_t cpu_tb, cpu_w;
  vic_req_t irq_req;
  logic [15:0] q[$];
  int n_mismatch, cmp_count;
  assign cpu_w = vic_cpu_t'(cpu_tb | 15'(ack));
  vic_top i_vic_top (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .cpu(cpu_w),
    .wdt_nmi_mode(wdt_nmi_mode), .wdt_overflow(wdt_overflow), .ext_pin(ext_pin),
    .periph_irq(periph_irq), .irq_req(irq_req), .psw_push(psw_push), .standby_release(standby_release));
  vic_cpu_model i_vic_cpu_model (.ref_clk(ref_clk), .rst_n(rst_n), .irq_req(irq_req), .delay(dly), .ack(ack));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // An empty queue yields unknown, so any unexpected result is a mismatch.
  function automatic logic [15:0] nxt();
    return q.size() ? q.pop_front() : 'x;
  endfunction
  always @(posedge ref_clk) begin
    rd_q <= bus.rd_en;
    v_q <= irq_req.valid;
    if (rd_q === 1'b1) chk("rdata", rdata, nxt());
    if (irq_req.valid === 1'b1 && v_q === 1'b0) chk("vector", irq_req.vector, nxt());
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    bus <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    bus <= '0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic w);
    q.push_back(e);
    bus <= '{1'b0, 1'b1, w, a, 16'h0000};
    @(posedge ref_clk);
    bus <= '0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic pc(input vic_cpu_t c);
    cpu_tb <= c;
    @(posedge ref_clk);
    cpu_tb <= '0;
    @(posedge ref_clk);
  endtask
  task automatic pe(input logic [8:0] p);
    periph_irq <= p;
    @(posedge ref_clk);
    periph_irq <= '0;
    @(posedge ref_clk);
  endtask
  task automatic wq(input int n);
    for (int i = 0; i < 100 && (q.size() > n || irq_req.valid !== 1'b0); i++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    logic [3:0] a;
    logic [3:0] b;
    void'($urandom(32'hE8B9));
    {rst_n, wdt_nmi_mode, wdt_overflow, ext_pin, periph_irq, dly} = '0;
    bus = '0;
    cpu_tb = '0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) rd(RA[i], {8'h00, RV[i]}, 1'b0);
    rd(ADDR_MASK_LO, RST_MASK16, 1'b1);
    rd(16'h0100, 16'h0000, 1'b0);
    pc(EI);
    pe(9'h001);
    repeat (8) @(posedge ref_clk);
    chk("standby", {15'h0000, standby_release}, 16'h0000);
    q.push_back(VEC_INT_BASE);
    wr(ADDR_MASK_LO, 16'hF000, 1'b1);
    @(posedge ref_clk);
    chk("standby", {15'h0000, standby_release}, 16'h0001);
    wq(0);
    chk("push", {8'h00, psw_push}, 16'h0082);
    rd(ADDR_PSW, 16'h0002, 1'b0);
    rd(ADDR_REQ_LO, 16'h0000, 1'b0);
    for (int i = 0; i < 9; i++) begin
      pc(EI);
      q.push_back(VEC_INT_BASE + 16'(2 * i));
      pe(9'(1 << i));
      wq(0);
    end
    repeat (3) begin
      a = 4'($urandom_range(0, 8));
      b = 4'($urandom_range(0, 8));
      dly <= 2'($urandom);
      pc(EI);
      q.push_back(VEC_INT_BASE + 16'(2 * (a < b ? a : b)));
      if (a != b) q.push_back(VEC_INT_BASE + 16'(2 * (a < b ? b : a)));
      pe(9'(1 << a) | 9'(1 << b));
      wq(int'(a != b));
      pc(EI);
      wq(0);
    end
    wr(ADDR_PRIO_LO, 16'hF7FF, 1'b1);
    pc(EI);
    q.push_back(VEC_INT_BASE + 16'h0010);
    pe(9'h101);
    wq(0);
    rd(ADDR_PSW, 16'h0000, 1'b0);
    pc(EI);
    repeat (10) @(posedge ref_clk);
    q.push_back(VEC_INT_BASE);
    pc(INTERRUPT_RETURN_INSTRUCTION);
    wq(0);
    wr(ADDR_PRIO_LO, 16'hFFFF, 1'b1);
    wdt_nmi_mode <= 1'b1;
    q.push_back(VEC_NMI);
    wdt_overflow <= 1'b1;
    @(posedge ref_clk);
    wdt_overflow <= 1'b0;
    wq(0);
    pc(EI);
    pe(9'h001);
    repeat (10) @(posedge ref_clk);
    q.push_back(VEC_INT_BASE);
    pc(INTERRUPT_RETURN_INSTRUCTION);
    wq(0);
    wr(ADDR_EDGE_RISE, 16'h0001, 1'b0);
    wr(ADDR_EDGE_FALL, 16'h0002, 1'b0);
    pc(EI);
    q.push_back(VEC_PIN0);
    ext_pin <= 2'b11;
    wq(0);
    pc(EI);
    q.push_back(VEC_PIN1);
    ext_pin <= 2'b01;
    wq(0);
    pc(EI);
    pc('{break_trap_instruction: 1'b1, default: '0});
    chk("push", {8'h00, psw_push}, 16'h0082);
    rd(ADDR_PSW, 16'h0002, 1'b0);
    chk("queue", 16'(q.size()), 16'h0000);
    conclude();
  end
endmodule // vic_top_test
bind vic_top vic_assertions i_vic_assertions (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
  .cpu(cpu), .wdt_nmi_mode(wdt_nmi_mode), .wdt_overflow(wdt_overflow), .ext_pin(ext_pin),
  .periph_irq(periph_irq), .irq_req(irq_req), .psw_push(psw_push), .standby_release(standby_release));
`default_nettype wire
